//--- rtl/hpcfg_ctl.sv
// Hot-plug slot configuration control: pin polarity, latch power-off,
// interlock drive and downstream power/reset sequencing per port.
// Assumes sensor pins are asynchronous; register port is on clk.
//
// Summary of operation
// - Config bit 0 inverts the attention button input on all ports.
// - Config bit 1 inverts the presence detect input on all ports.
// - Config bit 2 inverts the power fault input on all ports.
// - Config bit 3 inverts the retention latch sensor input on all ports.
// - Config bit 8 inverts the slot power good input on all ports.
// - Config bit 4 inverts the attention indicator output on all ports.
// - Config bit 5 inverts the power indicator output on all ports.
// - Config bit 6 inverts the slot power enable output on all ports.
// - Config bit 7 inverts the interlock output on all ports.
// - Bit 11 with latch capability removes power when latch is open.
// - Bit 12 makes latch inputs report interlock lock state instead.
// - Bit 13 clear: interlock command gives a 125 ms output pulse.
// - Bit 13 set: interlock command toggles the interlock output.
// - Reset mode selects power enable, power good or hot reset source.
// - Wait count times 10 ms after the reset source condition holds before releasing reset.
// - Wait count times 10 ms after reset assertion before power off.
//
// The implementer's own choice: strobed register access.
module hpcfg_ctl #(
  parameter int PORTS = 4,
  parameter int TICK_CYC = hpcfg_pkg::TICK_CYCLES,
  parameter int ILOCK_CYC = hpcfg_pkg::ILOCK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Hot reset request from the switch core
  input wire logic hot_reset,
  // Slot pins
  input wire logic [PORTS-1:0] attention_button_in,
  input wire logic [PORTS-1:0] presence_detect_in,
  input wire logic [PORTS-1:0] power_fault_in,
  input wire logic [PORTS-1:0] retention_latch_sensor_in,
  input wire logic [PORTS-1:0] slot_power_good_in,
  output logic [PORTS-1:0] attention_indicator_out,
  output logic [PORTS-1:0] power_indicator_out,
  output logic [PORTS-1:0] slot_power_enable_out,
  output logic [PORTS-1:0] interlock_drive_out,
  output logic [PORTS-1:0] downstream_reset_n_out,
  // Sensed levels, active true
  output logic [PORTS-1:0] sense_attn_btn,
  output logic [PORTS-1:0] sense_presence,
  output logic [PORTS-1:0] sense_pwr_fault,
  output logic [PORTS-1:0] sense_latch_open,
  output logic [PORTS-1:0] sense_lock_engaged,
  output logic [PORTS-1:0] sense_pwr_good
);

  // One command byte per port must fit the 32-bit command register
  if (PORTS < 1 || PORTS * hpcfg_pkg::CMD_STRIDE > 32) begin : g_bad_ports
    $error("PORTS must fit the command register");
  end
  if (TICK_CYC < 1 || ILOCK_CYC < 1) begin : g_bad_ticks
    $error("Tick counts must be positive");
  end

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int IW = $clog2(ILOCK_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [31:0] cmd_r;
  logic [31:0] cmd_nxt;
  logic [31:0] rdata_nxt;

  wire wr_cfg = reg_wr && reg_addr == hpcfg_pkg::CFG_OFFSET;
  wire wr_cmd = reg_wr && reg_addr == hpcfg_pkg::SLOT_CMD_OFFSET;

  wire inv_btn = cfg_r[hpcfg_pkg::INV_ATTN_BTN_BIT];
  wire inv_pres = cfg_r[hpcfg_pkg::INV_PRES_BIT];
  wire inv_pf = cfg_r[hpcfg_pkg::INV_PFAULT_BIT];
  wire inv_latch = cfg_r[hpcfg_pkg::INV_LATCH_BIT];
  wire inv_pg = cfg_r[hpcfg_pkg::INV_PGOOD_BIT];
  wire inv_ai = cfg_r[hpcfg_pkg::INV_ATTN_IND_BIT];
  wire inv_pi = cfg_r[hpcfg_pkg::INV_PWR_IND_BIT];
  wire inv_pe = cfg_r[hpcfg_pkg::INV_PWR_EN_BIT];
  wire inv_il = cfg_r[hpcfg_pkg::INV_ILOCK_BIT];
  wire latch_off_en = cfg_r[hpcfg_pkg::LATCH_PWR_OFF_BIT];
  wire latch_as_lock = cfg_r[hpcfg_pkg::LATCH_AS_LOCK_BIT];
  wire il_toggle = cfg_r[hpcfg_pkg::ILOCK_TOGGLE_BIT];
  wire [1:0] rst_src = cfg_r[hpcfg_pkg::RST_SRC_LSB +: 2];
  wire [7:0] p2r_cnt = cfg_r[hpcfg_pkg::P2R_LSB +: 8];
  wire [7:0] r2p_cnt = cfg_r[hpcfg_pkg::R2P_LSB +: 8];

  // Interlock command bit is write-one-to-act, never stored
  function automatic logic [31:0] cmd_store(input logic [31:0] w);
    logic [31:0] m;
    m = 32'h0;
    for (int p = 0; p < PORTS; p++) begin
      m[p*hpcfg_pkg::CMD_STRIDE +: hpcfg_pkg::CMD_STRIDE] = 8'h17;
    end
    return w & m;
  endfunction

  assign cfg_nxt = wr_cfg ? ((reg_wdata & hpcfg_pkg::CFG_WMASK) |
                             (cfg_r & ~hpcfg_pkg::CFG_WMASK)) : cfg_r;
  assign cmd_nxt = wr_cmd ? cmd_store(reg_wdata) : cmd_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and input polarity

  hpcfg_pkg::hpcfg_sense_t [PORTS-1:0] pin_s1_r;
  hpcfg_pkg::hpcfg_sense_t [PORTS-1:0] pin_s2_r;
  hpcfg_pkg::hpcfg_sense_t [PORTS-1:0] pin_raw;
  hpcfg_pkg::hpcfg_sense_t [PORTS-1:0] sense;
  logic hot_s1_r;
  logic hot_s2_r;

  // Prescaler shared by all ports
  logic [TW-1:0] pre_r;
  wire tick = pre_r == TW'(TICK_CYC - 1);
  logic [PORTS-1:0] ilock_cmd;
  logic [PORTS-1:0] ilock_r;
  logic [PORTS-1:0] pwr_en_r;
  logic [PORTS-1:0] rst_n_r;
  logic [PORTS-1:0] out_ai_nxt;
  logic [PORTS-1:0] out_pi_nxt;
  logic [PORTS-1:0] out_pe_nxt;
  logic [PORTS-1:0] out_il_nxt;
  logic [PORTS-1:0] latch_open;
  logic [PORTS-1:0] pwr_on_req;
  logic [PORTS-1:0] rst_cond;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      localparam int B = g * hpcfg_pkg::CMD_STRIDE;
      assign pin_raw[g] = '{attn_btn: attention_button_in[g],
                            presence: presence_detect_in[g],
                            pwr_fault: power_fault_in[g],
                            latch: retention_latch_sensor_in[g],
                            pwr_good: slot_power_good_in[g]};
      // Pins are active low; the inversion makes them active true, the xor applies the polarity bit
      assign sense[g].attn_btn = ~(pin_s2_r[g].attn_btn ^ inv_btn);
      assign sense[g].presence = ~(pin_s2_r[g].presence ^ inv_pres);
      assign sense[g].pwr_fault = ~(pin_s2_r[g].pwr_fault ^ inv_pf);
      assign sense[g].latch = ~(pin_s2_r[g].latch ^ inv_latch);
      assign sense[g].pwr_good = ~(pin_s2_r[g].pwr_good ^ inv_pg);
      // Latch reads as open; with bit 12 it is lock state instead
      assign latch_open[g] = sense[g].latch & ~latch_as_lock;
      assign ilock_cmd[g] = wr_cmd && reg_wdata[B + hpcfg_pkg::CMD_ILOCK];
      assign pwr_on_req[g] = cmd_r[B + hpcfg_pkg::CMD_PWR_CTL] &&
        !(latch_off_en && cmd_r[B + hpcfg_pkg::CMD_LATCH_CAP] && latch_open[g]);
      assign out_ai_nxt[g] = cmd_r[B + hpcfg_pkg::CMD_ATTN_IND] ^ inv_ai;
      assign out_pi_nxt[g] = cmd_r[B + hpcfg_pkg::CMD_PWR_IND] ^ inv_pi;
      assign out_pe_nxt[g] = pwr_en_r[g] ^ inv_pe;
      assign out_il_nxt[g] = ilock_r[g] ^ inv_il;

      // Reset source per mode; reserved mode holds reset asserted
      always_comb begin
        case (hpcfg_pkg::hpcfg_rst_src_t'(rst_src))
          hpcfg_pkg::HPCFG_RST_PWR_EN: rst_cond[g] = pwr_en_r[g];
          hpcfg_pkg::HPCFG_RST_PWR_GOOD: rst_cond[g] = pwr_en_r[g] & sense[g].pwr_good;
          hpcfg_pkg::HPCFG_RST_HOT: rst_cond[g] = pwr_en_r[g] & ~hot_s2_r;
          default: rst_cond[g] = 1'b0;
        endcase
      end

      // Power/reset sequencer
      typedef enum logic [1:0] {OFF, RAMP, ON, DRAIN} hpcfg_seq_t;
      hpcfg_seq_t st_r;
      logic [7:0] dcnt_r;
      logic [IW-1:0] pulse_r;
      wire dzero = dcnt_r == 8'h0;

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          st_r <= OFF;
          dcnt_r <= 8'h0;
          pwr_en_r[g] <= 1'b0;
          rst_n_r[g] <= 1'b0;
        end else if (clk_en) begin
          case (st_r)
            OFF: begin
              if (pwr_on_req[g]) begin
                st_r <= RAMP;
                pwr_en_r[g] <= 1'b1;
                dcnt_r <= p2r_cnt;
              end
            end
            RAMP: begin
              if (!pwr_on_req[g]) begin
                st_r <= DRAIN;
                dcnt_r <= r2p_cnt;
              end else if (!rst_cond[g]) begin
                dcnt_r <= p2r_cnt; // Restart wait until the selected reset source condition holds
              end else if (dzero) begin
                st_r <= ON;
                rst_n_r[g] <= 1'b1;
              end else if (tick) begin
                dcnt_r <= dcnt_r - 8'h1;
              end
            end
            ON: begin
              if (!pwr_on_req[g]) begin
                st_r <= DRAIN;
                rst_n_r[g] <= 1'b0;
                dcnt_r <= r2p_cnt;
              end else if (!rst_cond[g]) begin
                st_r <= RAMP;
                rst_n_r[g] <= 1'b0;
                dcnt_r <= p2r_cnt;
              end
            end
            DRAIN: begin
              rst_n_r[g] <= 1'b0;
              if (dzero) begin
                st_r <= OFF;
                pwr_en_r[g] <= 1'b0;
              end else if (tick) begin
                dcnt_r <= dcnt_r - 8'h1;
              end
            end
            default: st_r <= OFF;
          endcase
        end
      end

      // Interlock: pulse or toggle
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ilock_r[g] <= 1'b0;
          pulse_r <= '0;
        end else if (clk_en) begin
          if (ilock_cmd[g] && il_toggle) begin
            ilock_r[g] <= ~ilock_r[g];
          end else if (ilock_cmd[g]) begin
            ilock_r[g] <= 1'b1;
            pulse_r <= IW'(ILOCK_CYC - 1);
          end else if (ilock_r[g] && !il_toggle) begin
            if (pulse_r == '0) begin
              ilock_r[g] <= 1'b0;
            end else begin
              pulse_r <= pulse_r - IW'(1);
            end
          end
        end
      end

      pulse_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ilock_r[g] && !il_toggle && pulse_r != '0) |=> ilock_r[g])
        else $error("Interlock pulse ended early");
      reset_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == RAMP && !dzero) |=> !rst_n_r[g])
        else $error("Reset released before delay");
      power_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == DRAIN && !dzero) |=> pwr_en_r[g])
        else $error("Power removed before delay");
      latch_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && st_r == ON && latch_off_en && latch_open[g] &&
         cmd_r[B + hpcfg_pkg::CMD_LATCH_CAP]) |=> st_r == DRAIN)
        else $error("Open latch did not remove power");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  function automatic logic [31:0] pack_ports(input logic [PORTS-1:0] v);
    return 32'(v);
  endfunction

  always_comb begin
    case (reg_addr)
      hpcfg_pkg::CFG_OFFSET: rdata_nxt = cfg_r & hpcfg_pkg::CFG_RMASK;
      hpcfg_pkg::SLOT_CMD_OFFSET: rdata_nxt = cmd_r;
      hpcfg_pkg::SLOT_STAT_OFFSET: rdata_nxt = pack_ports(pwr_en_r) |
        (pack_ports(rst_n_r) << 8) | (pack_ports(ilock_r) << 16);
      default: rdata_nxt = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= hpcfg_pkg::CFG_RESET;
      cmd_r <= 32'h0;
      reg_rdata <= 32'h0;
      pre_r <= '0;
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      hot_s1_r <= 1'b0;
      hot_s2_r <= 1'b0;
    end else if (clk_en) begin
      cfg_r <= cfg_nxt;
      cmd_r <= cmd_nxt;
      reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
      pre_r <= tick ? '0 : pre_r + TW'(1);
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      hot_s1_r <= hot_reset;
      hot_s2_r <= hot_s1_r;
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      attention_indicator_out <= '0;
      power_indicator_out <= '0;
      slot_power_enable_out <= '0;
      interlock_drive_out <= '0;
      downstream_reset_n_out <= '0;
      sense_attn_btn <= '0;
      sense_presence <= '0;
      sense_pwr_fault <= '0;
      sense_latch_open <= '0;
      sense_lock_engaged <= '0;
      sense_pwr_good <= '0;
    end else if (clk_en) begin
      attention_indicator_out <= out_ai_nxt;
      power_indicator_out <= out_pi_nxt;
      slot_power_enable_out <= out_pe_nxt;
      interlock_drive_out <= out_il_nxt;
      downstream_reset_n_out <= rst_n_r;
      for (int p = 0; p < PORTS; p++) begin
        sense_attn_btn[p] <= sense[p].attn_btn;
        sense_presence[p] <= sense[p].presence;
        sense_pwr_fault[p] <= sense[p].pwr_fault;
        sense_latch_open[p] <= latch_open[p];
        sense_lock_engaged[p] <= sense[p].latch & latch_as_lock;
        sense_pwr_good[p] <= sense[p].pwr_good;
      end
    end
  end

  pe_polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> slot_power_enable_out == ($past(pwr_en_r) ^ {PORTS{$past(inv_pe)}}))
    else $error("Power enable polarity wrong");
  il_polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> interlock_drive_out == ($past(ilock_r) ^ {PORTS{$past(inv_il)}}))
    else $error("Interlock polarity wrong");
  cfg_reset_a: assert property (@(posedge clk)
    !rst_n |=> cfg_r == hpcfg_pkg::CFG_RESET)
    else $error("Config reset value wrong");
  rdata_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !reg_rd) |=> reg_rdata == 32'h0)
    else $error("Read data not idle");

endmodule

//--- rtl/hpcfg_pkg.sv
// Package for the hot-plug slot configuration control block.
// Assumes one core clock at 250 MHz and a plain register port.
package hpcfg_pkg;
  // Register map
  localparam logic [11:0] CFG_OFFSET = 12'h408;
  localparam logic [11:0] SLOT_CMD_OFFSET = 12'h500;
  localparam logic [11:0] SLOT_STAT_OFFSET = 12'h504;

  // Configuration field positions
  localparam int INV_ATTN_BTN_BIT = 0;
  localparam int INV_PRES_BIT = 1;
  localparam int INV_PFAULT_BIT = 2;
  localparam int INV_LATCH_BIT = 3;
  localparam int INV_ATTN_IND_BIT = 4;
  localparam int INV_PWR_IND_BIT = 5;
  localparam int INV_PWR_EN_BIT = 6;
  localparam int INV_ILOCK_BIT = 7;
  localparam int INV_PGOOD_BIT = 8;
  localparam int LATCH_PWR_OFF_BIT = 11;
  localparam int LATCH_AS_LOCK_BIT = 12;
  localparam int ILOCK_TOGGLE_BIT = 13;
  localparam int RST_SRC_LSB = 14;
  localparam int P2R_LSB = 16;
  localparam int R2P_LSB = 24;
  localparam logic [31:0] CFG_RESET = 32'h1414_0800;
  localparam logic [31:0] CFG_WMASK = 32'hffff_f9ff;
  localparam logic [31:0] CFG_RMASK = 32'hffff_ffff;

  // Slot command register fields, per port: base bit = port * 8
  localparam int CMD_STRIDE = 8;
  localparam int CMD_PWR_CTL = 0;
  localparam int CMD_ATTN_IND = 1;
  localparam int CMD_PWR_IND = 2;
  localparam int CMD_ILOCK = 3;
  localparam int CMD_LATCH_CAP = 4;

  // Reset source modes
  typedef enum logic [1:0] {
    HPCFG_RST_PWR_EN = 2'h0,
    HPCFG_RST_PWR_GOOD = 2'h1,
    HPCFG_RST_HOT = 2'h2,
    HPCFG_RST_RSVD = 2'h3
  } hpcfg_rst_src_t;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 10;
  localparam int ILOCK_PULSE_MS = 125;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int ILOCK_CYCLES = ILOCK_PULSE_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic attn_btn;
    logic presence;
    logic pwr_fault;
    logic latch;
    logic pwr_good;
  } hpcfg_sense_t;

  typedef struct packed {
    logic attn_ind;
    logic pwr_ind;
    logic pwr_en;
    logic ilock;
    logic rst_n;
  } hpcfg_drive_t;
endpackage

//--- sim/hpcfg_slot_model.sv
// Slot side model: sensors, latch and a power controller with power good.
// Assumes the bench mirrors the pin polarity bits of the configuration.
module hpcfg_slot_model #(
  parameter int PORTS = 4,
  parameter int PG_DLY = 30
) (
  // Clock
  input wire logic clk,
  // Polarity bits 8:0 as programmed
  input wire logic [8:0] inv,
  // Slot state, active true
  input wire logic [PORTS-1:0] btn,
  input wire logic [PORTS-1:0] pres,
  input wire logic [PORTS-1:0] fault,
  input wire logic [PORTS-1:0] latch,
  // Pins
  input wire logic [PORTS-1:0] pwr_en_pin,
  output logic [PORTS-1:0] attention_button_in,
  output logic [PORTS-1:0] presence_detect_in,
  output logic [PORTS-1:0] power_fault_in,
  output logic [PORTS-1:0] retention_latch_sensor_in,
  output logic [PORTS-1:0] slot_power_good_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [PORTS];
  logic [PORTS-1:0] good;
  //////////////////////////////////////////////////////////////////////////////
  // Pins are active low unless the matching polarity bit is set
  assign attention_button_in = ~btn ^ {PORTS{inv[0]}};
  assign presence_detect_in = ~pres ^ {PORTS{inv[1]}};
  assign power_fault_in = ~fault ^ {PORTS{inv[2]}};
  assign retention_latch_sensor_in = ~latch ^ {PORTS{inv[3]}};
  assign slot_power_good_in = ~good ^ {PORTS{inv[8]}};
  // Supply ramps for PG_DLY cycles before it reports good
  always_ff @(posedge clk) begin
    for (int p = 0; p < PORTS; p++) begin
      cnt[p] <= (pwr_en_pin[p] ^ inv[6]) ? ((cnt[p] < PG_DLY) ? cnt[p] + 1 : cnt[p]) : 0;
    end
  end
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      good[p] = (cnt[p] >= PG_DLY);
    end
  end
endmodule

//--- sim/tb.sv
// Bench for the hot-plug configuration block over its register port.
// Assumes shortened tick and interlock counts and four ports.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 4;
  localparam int T = 10;
  localparam int ILK = 20;
  localparam int PG = 30;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic hot_reset = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] cfg_s = 32'h1414_0800;
  logic [31:0] reg_rdata, d;
  logic [P-1:0] btn = '0, pres = '0, flt = '0, lat = '0;
  logic [P-1:0] ab, pd, pf, ls, pg, ai, pi, pe, il, dr;
  logic [P-1:0] s_ab, s_pd, s_pf, s_lo, s_le, s_pg;
  wire [2:0] mon = {il[0], pe[0], dr[0]};
  int num_errors = 0;
  int checked = 0;
  int n;
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  hpcfg_ctl #(.PORTS(P), .TICK_CYC(T), .ILOCK_CYC(ILK)) u_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hot_reset(hot_reset),
    .attention_button_in(ab), .presence_detect_in(pd), .power_fault_in(pf),
    .retention_latch_sensor_in(ls), .slot_power_good_in(pg),
    .attention_indicator_out(ai), .power_indicator_out(pi),
    .slot_power_enable_out(pe), .interlock_drive_out(il), .downstream_reset_n_out(dr),
    .sense_attn_btn(s_ab), .sense_presence(s_pd), .sense_pwr_fault(s_pf),
    .sense_latch_open(s_lo), .sense_lock_engaged(s_le), .sense_pwr_good(s_pg));
  hpcfg_slot_model #(.PORTS(P), .PG_DLY(PG)) u_slot (
    .clk(clk), .inv(cfg_s[8:0]), .btn(btn), .pres(pres), .fault(flt), .latch(lat),
    .pwr_en_pin(pe), .attention_button_in(ab), .presence_detect_in(pd),
    .power_fault_in(pf), .retention_latch_sensor_in(ls), .slot_power_good_in(pg));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic setcfg(input logic [31:0] v);
    cfg_s = v;
    wr(12'h408, v);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Bounded wait on one monitored bit; a hang ends the run
  task automatic waitfor(input int sel, input logic lvl, input int max, output int cnt);
    cnt = 0;
    #1;
    while (mon[sel] !== lvl) begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > max) begin
        num_errors++;
        $display("mismatch t=%0t wait expired on %0d", $time, sel);
        summarize();
      end
    end
  endtask
  task summarize;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h408, d);
    `CHK(d, 32'h1414_0800)
    rd(12'h40c, d);
    `CHK(d, 32'h0000_0000)
    wr(12'h408, 32'hffff_ffff);
    rd(12'h408, d);
    `CHK(d, 32'hffff_f9ff)
    btn <= 4'h5;
    pres <= 4'h3;
    flt <= 4'h9;
    lat <= 4'h6;
    // Second pass inverts the enable pin too; slot stays off and good stays low
    for (int i = 0; i < 2; i++) begin
      setcfg(i ? 32'h0000_094f : 32'h0000_0800);
      settle(PG + 8);
      `CHK(s_ab, btn)
      `CHK(s_pd, pres)
      `CHK(s_pf, flt)
      `CHK(s_lo, lat)
      `CHK(s_pg, 4'h0)
    end
    setcfg(32'h0000_1800);
    settle(6);
    `CHK(s_le, lat)
    `CHK(s_lo, 4'h0)
    lat <= 4'h0;
    wr(12'h500, 32'h0606_0606);
    for (int i = 0; i < 2; i++) begin
      setcfg(i ? 32'h0000_08f0 : 32'h0000_0800);
      settle(3);
      `CHK(ai, i ? 4'h0 : 4'hf)
      `CHK(pi, i ? 4'h0 : 4'hf)
      `CHK(pe, i ? 4'hf : 4'h0)
      `CHK(il, i ? 4'hf : 4'h0)
    end
    wr(12'h500, 32'h0);
    for (int m = 0; m < 4; m++) begin
      setcfg(32'h0203_0800 | (32'(m) << 14));
      hot_reset <= (m == 2);
      wr(12'h500, 32'h1);
      if (m >= 2) begin
        settle(60);
        `CHK(dr[0], 1'b0)
        hot_reset <= 1'b0;
      end
      if (m < 3) begin
        waitfor(0, 1'b1, 120, n);
        `CHK(n >= 2*T + (m == 1 ? PG : 0) && n <= 3*T + 8 + (m == 1 ? PG + 4 : 0), 1'b1)
      end
      wr(12'h500, 32'h0);
      settle(2);
      `CHK(dr[0], 1'b0)
      waitfor(1, 1'b0, 40, n);
      `CHK(n >= T - 2 && n <= 2*T + 6, 1'b1)
    end
    setcfg(32'h0000_0800);
    wr(12'h500, 32'h1);
    waitfor(0, 1'b1, 6, n);
    wr(12'h500, 32'h0);
    waitfor(1, 1'b0, 6, n);
    lat <= 4'h1;
    // Latch open: only capability plus auto power-off removes power
    for (int i = 0; i < 3; i++) begin
      setcfg(i == 2 ? 32'h0000_0000 : 32'h0000_0800);
      wr(12'h500, i == 1 ? 32'h01 : 32'h11);
      settle(20);
      `CHK(pe[0], i != 0 ? 1'b1 : 1'b0)
      wr(12'h500, 32'h0);
      settle(5);
    end
    // Latch opening while powered drops the slot
    lat <= 4'h0;
    setcfg(32'h0000_0800);
    wr(12'h500, 32'h11);
    waitfor(1, 1'b1, 8, n);
    lat <= 4'h1;
    waitfor(1, 1'b0, 12, n);
    lat <= 4'h0;
    wr(12'h500, 32'h0);
    setcfg(32'h0000_0000);
    wr(12'h500, 32'h08);
    waitfor(2, 1'b1, 6, n);
    waitfor(2, 1'b0, ILK + 4, n);
    `CHK(n >= ILK - 2 && n <= ILK + 2, 1'b1)
    setcfg(32'h0000_2000);
    wr(12'h500, 32'h0800_0000);
    settle(3);
    `CHK(il, 4'h8)
    rd(12'h504, d);
    `CHK(d, 32'h0008_0000)
    wr(12'h500, 32'h0800_0000);
    settle(3);
    `CHK(il, 4'h0)
    // Frozen clock enable must drop the command
    clk_en <= 1'b0;
    wr(12'h500, 32'h0800_0000);
    clk_en <= 1'b1;
    settle(3);
    `CHK(il, 4'h0)
    summarize();
  end
endmodule
